// ---- design/dmc_map.svh ----
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
// =====================================================================
// timing figures (ns unless noted) and derived cycle counts at 100 MHz
`define DMC_CLK_NS 10
`define DMC_PWRUP_US 100
`define DMC_PWRUP_CYC ((`DMC_PWRUP_US * 1000 + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_INIT_CYCLES 8
`define DMC_REF_MS 8
`define DMC_REF_ROWS 512
`define DMC_REF_INTERVAL_CYC ((`DMC_REF_MS * 1000000 / `DMC_REF_ROWS) / `DMC_CLK_NS)
`define DMC_RC_NS 160
`define DMC_RAS_MIN_NS 80
`define DMC_RP_NS 70
`define DMC_RCD_NS 25
`define DMC_RAD_NS 17
`define DMC_AA_NS 45
`define DMC_CAS_NS 20
`define DMC_PC_NS 50
`define DMC_CP_NS 10
`define DMC_CSR_NS 10
`define DMC_CHR_NS 15
`define DMC_RAS_MAX_NS 10000
`define DMC_RASP_MAX_NS 100000
`define DMC_CEIL(ns) (((ns) + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_FLOOR(ns) ((ns) / `DMC_CLK_NS)
`define DMC_ROW_BITS 10
`define DMC_COL_BITS 10
`endif

// ---- design/dmc_pkg.sv ----
package dmc_pkg;
    // =================================================================
    // types
    typedef struct packed {
        logic we;
        logic [19:0] addr;
        logic [8:0] wdata;
    } dmc_req_t;

    typedef struct packed {
        logic [9:0] a;
        logic ras_n;
        logic cas_n;
        logic ninth_bit_column_strobe_n;
        logic we_n;
    } dmc_pins_t;

    typedef enum logic [3:0] {
        ST_PWRUP = 4'b0000,
        ST_IDLE = 4'b0001,
        ST_ROW = 4'b0011,
        ST_COL = 4'b0010,
        ST_CAS = 4'b0110,
        ST_PRE = 4'b0111,
        ST_CBR_CAS = 4'b0101,
        ST_CBR_RAS = 4'b0100,
        ST_RASONLY = 4'b1100
    } dmc_state_t;
endpackage : dmc_pkg

// ---- design/dmc_timer.sv ----
`timescale 1ns/1ps
`include "dmc_map.svh"
module dmc_timer import dmc_pkg::*; #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [W-1:0] value,
    // status
    output logic done
);
    // =================================================================
    // down counter; done while zero
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    assign cnt_d = load ? value : (cnt_q != '0 ? cnt_q - W'(1) : cnt_q);
    assign done = (cnt_q == '0);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_q <= '0;
        else cnt_q <= cnt_d;
    end
endmodule : dmc_timer

// ---- design/dmc_ctrl.sv ----
`timescale 1ns/1ps
`include "dmc_map.svh"
// How it works
// - all 512 rows refreshed every 8 ms
// - 100 us pause, eight row cycles first
// - ninth bit separate pins, strobe with column
// - row strobe never held past limits
// - random cycles spaced at least 160 ns
// - refresh: column strobe leads row strobe
// - refresh by column-before-row cycles
module dmc_ctrl import dmc_pkg::*; #(
    parameter int PWRUP_CYC = `DMC_PWRUP_CYC,
    parameter int REF_INT_CYC = `DMC_REF_INTERVAL_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user request
    input wire logic req_valid,
    input wire dmc_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [8:0] rsp_rdata,
    output logic init_done,
    // memory pins
    output dmc_pins_t pins,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_n,
    output logic d9_in,
    input wire logic d9_out
);
    // =================================================================
    // timing counts
    localparam int TW = 24;
    localparam int RAD_C = `DMC_CEIL(`DMC_RAD_NS);
    localparam int RCD_C = `DMC_CEIL(`DMC_RCD_NS) - RAD_C;
    localparam int AA_C = `DMC_CEIL(`DMC_AA_NS);
    localparam int CAS_C = (AA_C > `DMC_CEIL(`DMC_CAS_NS)) ? AA_C : `DMC_CEIL(`DMC_CAS_NS);
    localparam int RAS_C = `DMC_CEIL(`DMC_RAS_MIN_NS);
    localparam int RP_C = `DMC_CEIL(`DMC_RC_NS) - RAS_C;
    localparam int CSR_C = `DMC_CEIL(`DMC_CSR_NS);

    // =================================================================
    // state
    dmc_state_t st_q, st_d;
    dmc_req_t cur_q;
    logic [3:0] init_cnt_q;
    logic init_q;
    logic [9:0] ref_owed_q;
    logic [TW-1:0] ref_cnt_q;
    logic ref_due;
    logic t_load;
    logic [TW-1:0] t_val;
    logic t_done;
    logic [9:0] a_q;
    logic ras_q, cas_q, we_q, oe_q;
    logic [7:0] dqo_q;
    logic d9_q;
    logic rsp_q;
    logic [8:0] rd_q;
    logic rst_first_q;

    dmc_timer #(.W(TW)) u_tmr (
        .clk(clk),
        .rst(rst),
        .load(t_load),
        .value(t_val),
        .done(t_done)
    );

    // =================================================================
    // refresh scheduling
    // one refresh per interval
    assign ref_due = (ref_owed_q != '0);
    wire ref_tick = (ref_cnt_q == TW'(REF_INT_CYC - 1));
    // only counted when the refresh really starts, not while the timer still runs
    wire ref_take = (st_q == ST_IDLE) && t_done && ref_due && init_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_cnt_q <= '0;
            ref_owed_q <= '0;
        end else begin
            ref_cnt_q <= ref_tick ? '0 : ref_cnt_q + TW'(1);
            // a new tick and a refresh taken in the same cycle cancel out
            ref_owed_q <= ref_owed_q + 10'(ref_tick) - 10'(ref_take);
        end
    end

    // =================================================================
    // next state
    assign req_ready = (st_q == ST_IDLE) && t_done && init_q && !ref_due;
    wire take = req_ready && req_valid;

    always_comb begin
        st_d = st_q;
        t_load = 1'b0;
        t_val = '0;
        case (st_q)
            ST_PWRUP: begin
                if (t_done) begin
                    st_d = ST_RASONLY;
                    t_load = 1'b1;
                    t_val = TW'(RAS_C);
                end
            end
            ST_IDLE: begin
                if (t_done && !init_q) begin
                    st_d = ST_RASONLY;
                    t_load = 1'b1;
                    t_val = TW'(RAS_C);
                end else if (t_done && ref_due && init_q) begin
                    st_d = ST_CBR_CAS;
                    t_load = 1'b1;
                    t_val = TW'(CSR_C);
                end else if (take) begin
                    st_d = ST_ROW;
                    t_load = 1'b1;
                    t_val = TW'(RAD_C);
                end
            end
            ST_RASONLY, ST_CBR_RAS: begin
                // row strobe released at minimum width
                if (t_done) begin
                    st_d = ST_IDLE;
                    t_load = 1'b1;
                    t_val = TW'(RP_C);
                end
            end
            ST_CBR_CAS: begin
                if (t_done) begin
                    st_d = ST_CBR_RAS;
                    t_load = 1'b1;
                    t_val = TW'(RAS_C);
                end
            end
            ST_ROW: begin
                if (t_done) begin
                    st_d = ST_COL;
                    t_load = 1'b1;
                    t_val = TW'(RCD_C);
                end
            end
            ST_COL: begin
                if (t_done) begin
                    st_d = ST_CAS;
                    t_load = 1'b1;
                    t_val = TW'(CAS_C);
                end
            end
            ST_CAS: begin
                if (t_done) begin
                    st_d = ST_PRE;
                    t_load = 1'b1;
                    t_val = TW'(RP_C);
                end
            end
            ST_PRE: begin
                if (t_done) st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
        if (st_q == ST_PWRUP && rst_first_q) begin
            // stay in the pause; a stray row strobe here would break it
            st_d = ST_PWRUP;
            t_load = 1'b1;
            t_val = TW'(PWRUP_CYC);
        end
    end

    // first cycle after reset loads the power-up pause
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rst_first_q <= 1'b1;
        else rst_first_q <= 1'b0;
    end

    // =================================================================
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_PWRUP;
            cur_q <= '0;
            init_cnt_q <= '0;
            init_q <= 1'b0;
        end else begin
            st_q <= st_q == ST_PWRUP && rst_first_q ? ST_PWRUP : st_d;
            if (take) cur_q <= req;
            if (st_q == ST_RASONLY && st_d == ST_IDLE && !init_q) begin
                init_cnt_q <= init_cnt_q + 4'(1);
                if (init_cnt_q == 4'(`DMC_INIT_CYCLES - 1)) init_q <= 1'b1;
            end
        end
    end

    // row from high half, column from low half
    wire [9:0] a_d = (st_d == ST_ROW) ? cur_q.addr[19:10] : cur_q.addr[9:0];
    wire ras_d = (st_d == ST_ROW) || (st_d == ST_COL) || (st_d == ST_CAS)
        || (st_d == ST_RASONLY) || (st_d == ST_CBR_RAS);
    wire cas_d = (st_d == ST_CAS) || (st_d == ST_CBR_CAS) || (st_d == ST_CBR_RAS);
    wire wr_d = cur_q.we && ((st_d == ST_ROW) || (st_d == ST_COL) || (st_d == ST_CAS));
    wire rd_sample = (st_q == ST_CAS) && t_done && !cur_q.we;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_q <= '0;
            ras_q <= 1'b0;
            cas_q <= 1'b0;
            we_q <= 1'b0;
            oe_q <= 1'b0;
            dqo_q <= '0;
            d9_q <= 1'b0;
            rsp_q <= 1'b0;
            rd_q <= '0;
        end else begin
            a_q <= (st_d == ST_ROW && st_q == ST_IDLE) ? req.addr[19:10] : a_d;
            ras_q <= ras_d;
            cas_q <= cas_d;
            we_q <= (st_q == ST_IDLE && take) ? req.we : wr_d;
            oe_q <= (st_q == ST_IDLE && take) ? req.we : wr_d;
            dqo_q <= take ? req.wdata[7:0] : dqo_q;
            d9_q <= take ? req.wdata[8] : d9_q;
            rsp_q <= rd_sample;
            // ninth bit from its own output pin
            if (rd_sample) rd_q <= {d9_out, dq_in};
        end
    end

    // =================================================================
    // pins
    // ninth strobe follows column strobe
    assign pins = '{a: a_q, ras_n: !ras_q, cas_n: !cas_q, ninth_bit_column_strobe_n: !cas_q, we_n: !we_q};
    assign dq_out = dqo_q;
    assign dq_oe_n = !oe_q;
    assign d9_in = d9_q;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rd_q;
    assign init_done = init_q;
endmodule : dmc_ctrl

// ---- sim/dmc_chk.sv ----
`timescale 1ns/1ps
module dmc_chk import dmc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user side
    input wire logic req_valid,
    input wire dmc_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic init_done,
    // memory side
    input wire dmc_pins_t pins
);
    // ========
    // row strobe low time, counted since a long pulse exceeds any repetition
    logic [9:0] lo_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_q <= 10'h000;
        end else begin
            lo_q <= pins.ras_n ? 10'h000 : lo_q + 10'h001;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ras_width_a: assert property (lo_q < 10'h3e8)
        else $error("row strobe too long");
    strobe_pair_a: assert property (pins.ninth_bit_column_strobe_n == pins.cas_n)
        else $error("ninth strobe apart");
    refresh_lead_a: assert property ($fell(pins.ras_n) && !pins.cas_n |-> !$past(pins.cas_n))
        else $error("refresh lead short");
    col_order_a: assert property ($fell(pins.cas_n) && !pins.ras_n |-> !$past(pins.ras_n, 2))
        else $error("column strobe early");
    col_delay_a: assert property ($fell(pins.ras_n) && pins.cas_n && init_done |-> ##[1:6] !pins.cas_n)
        else $error("column strobe late");
    row_pre_a: assert property ($rose(pins.ras_n) |-> pins.ras_n [*7])
        else $error("precharge short");
    init_gate_a: assert property (!init_done |-> !req_ready)
        else $error("taken before init");
    read_answer_a: assert property (req_valid && req_ready && !req.we |-> ##[6:14] rsp_valid)
        else $error("read unanswered");
endmodule : dmc_chk
bind dmc_ctrl dmc_chk i_chk (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .init_done(init_done), .pins(pins));

// ---- sim/dmc_mem.sv ----
`timescale 1ns/1ps
module dmc_mem import dmc_pkg::*; (
    // strobes and data in
    input wire dmc_pins_t pins,
    input wire logic [7:0] dq_out,
    input wire logic d9_in,
    input wire logic dq_oe_n,
    input wire logic slow,
    // data out and counts
    output logic [7:0] dq_in,
    output logic d9_out,
    output int n_ras,
    output int n_cbr
);
    // ========
    // row then column word
    logic [8:0] mem [int];
    logic [9:0] row;
    logic [8:0] rd = 9'h0a5;
    initial n_ras = 0;
    initial n_cbr = 0;
    always @(negedge pins.ras_n) begin
        row = pins.a;
        n_ras++;
        if (!pins.cas_n) n_cbr++;
    end
    always @(negedge pins.cas_n) begin
        if (!pins.ras_n && !pins.we_n) begin
            // an undriven shared bus stores garbage, so a missing enable shows on read
            mem[{row, pins.a}] = {d9_in, dq_oe_n ? 8'hxx : dq_out};
        end else if (!pins.ras_n) begin
            rd = ~rd;
            #(slow ? 40 : 5);
            rd = mem.exists({row, pins.a}) ? mem[{row, pins.a}] : 9'h000;
        end
    end
    // released lines never keep the old value
    always @(posedge pins.cas_n) rd = ~rd;
    assign {d9_out, dq_in} = rd;
endmodule : dmc_mem

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb import dmc_pkg::*;;
    localparam int PW = 20;
    localparam int RI = 200;
    logic clk, rst, req_valid, req_ready, rsp_valid, init_done, slow, dq_oe_n, d9_in, d9_out;
    dmc_req_t req;
    dmc_pins_t pins;
    logic [8:0] rsp_rdata, ev;
    logic [8:0] shadow [int];
    logic [8:0] exp_q [$];
    logic [19:0] aq [$];
    logic [19:0] ad;
    logic [7:0] dq_in, dq_out;
    int seed = 76, num_errors = 0, n_tests = 0, cyc = 0, n_ras, n_cbr, r0, c0, k;
    dmc_ctrl #(.PWRUP_CYC(PW), .REF_INT_CYC(RI)) i_dut (.clk(clk), .rst(rst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .init_done(init_done), .pins(pins), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .d9_in(d9_in), .d9_out(d9_out));
    dmc_mem i_mem (.pins(pins), .dq_out(dq_out), .d9_in(d9_in), .dq_oe_n(dq_oe_n),
        .slow(slow), .dq_in(dq_in),
        .d9_out(d9_out), .n_ras(n_ras), .n_cbr(n_cbr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ========
    // response watcher
    always @(posedge clk) begin
        if (rsp_valid === 1'b1) begin
            ev = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            `CHK("rdata", ev, rsp_rdata)
        end
    end
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic access(input logic we, input logic [19:0] a, input logic [8:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{we: we, addr: a, wdata: wd};
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        req_valid <= 1'b0;
        if (req_ready !== 1'b1) begin
            num_errors++;
            conclude();
        end
        if (we) shadow[a] = wd;
        else exp_q.push_back(shadow[a]);
    endtask : access
    task automatic reset_init;
        int r;
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        r = n_ras;
        repeat (PW - 2) @(posedge clk);
        `CHK("pause", r, n_ras)
        k = 0;
        while (init_done !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        `CHK("init", 1'b1, init_done)
        `CHK("rows", 1'b1, 1'(n_ras - r >= 8))
    endtask : reset_init
    task automatic drain;
        k = 0;
        while (exp_q.size() > 0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        `CHK("drained", 0, exp_q.size())
    endtask : drain
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        reset_init();
        r0 = n_cbr;
        c0 = cyc;
        // corner rows first, then random words, each written and read back to back
        for (int i = 0; i < 24; i++) begin
            ad = (i == 0) ? 20'h0_0000 : (i == 1) ? 20'hf_ffff : 20'($random(seed));
            slow <= i[0];
            aq.push_back(ad);
            access(1'b1, ad, 9'($random(seed)));
            access(1'b0, ad, 9'h000);
        end
        foreach (aq[j]) access(1'b0, aq[j], 9'h000);
        drain();
        `CHK("refresh", 1'b1, 1'(n_cbr - r0 >= (cyc - c0) / RI - 1))
        reset_init();
        access(1'b1, 20'h5_a5a5, 9'h15a);
        access(1'b0, 20'h5_a5a5, 9'h000);
        drain();
        conclude();
    end
endmodule : tb
